/* ctrt_cfg.svh */
// Purpose: shared sizing constants for the request/response tracker ends
// Assumes: one requester and one responder joined by ctrt_link_if
// Notes: defaults only; modules take them as parameter defaults, and CTRT_RST_STATE as the reset value
`ifndef CTRT_CFG_SVH
`define CTRT_CFG_SVH
`define CTRT_MAX_OUT 4
`define CTRT_TID_W 2
`define CTRT_ADDR_W 8
`define CTRT_DATA_W 32
`define CTRT_MEM_DEPTH 16
`define CTRT_RST_STATE '0
`endif

/* ctrt_pkg.sv */
// Purpose: types shared by both ends of the tracker link
// Assumes: nothing beyond the cfg header
// Notes: enums carry explicit widths so they can cross ports
package ctrt_pkg;
   // request kinds; write_nr is the one kind that never gets an answer
   typedef enum logic [2:0] {
      ctrt_rq_read_home,
      ctrt_rq_read_owner,
      ctrt_rq_rfo_home,
      ctrt_rq_castout,
      ctrt_rq_write_nr
   } ctrt_req_e;
   // response codes as they travel on the link
   typedef enum logic [2:0] {
      ctrt_rs_done,
      ctrt_rs_interv,
      ctrt_rs_done_interv,
      ctrt_rs_data_only,
      ctrt_rs_not_owner,
      ctrt_rs_retry,
      ctrt_rs_error
   } ctrt_rsp_e;
   // how the requester reports an answer to its user
   typedef enum logic [1:0] {
      ctrt_cl_complete,
      ctrt_cl_interv,
      ctrt_cl_conflict,
      ctrt_cl_error
   } ctrt_class_e;
endpackage : ctrt_pkg

/* ctrt_link_if.sv */
// Purpose: request and response channels between requester and responder
// Assumes: both ends on sys_clk, valid/ready handshakes
// Notes: a beat moves on a rising edge with valid and ready both high
`timescale 1ns/100ps
`include "ctrt_cfg.svh"
interface ctrt_link_if #(
   parameter int TID_W = `CTRT_TID_W,
   parameter int ADDR_W = `CTRT_ADDR_W,
   parameter int DATA_W = `CTRT_DATA_W
) (
   input wire logic sys_clk,
   input wire logic nrst
);
   logic req_valid;
   logic req_ready;
   ctrt_pkg::ctrt_req_e req_kind;
   logic [TID_W-1:0] req_tid;
   logic [ADDR_W-1:0] req_addr;
   logic [DATA_W-1:0] req_data;
   logic rsp_valid;
   logic rsp_ready;
   ctrt_pkg::ctrt_rsp_e rsp_code;
   logic [TID_W-1:0] rsp_tid;
   logic [DATA_W-1:0] rsp_data;

   modport requester (
      output req_valid, req_kind, req_tid, req_addr, req_data, rsp_ready,
      input req_ready, rsp_valid, rsp_code, rsp_tid, rsp_data
   );
   modport responder (
      input req_valid, req_kind, req_tid, req_addr, req_data, rsp_ready,
      output req_ready, rsp_valid, rsp_code, rsp_tid, rsp_data
   );
endinterface : ctrt_link_if

/* ctrt_responder.sv */
// Purpose: peer end; serves requests from a local memory and answers all but posted writes
// Assumes: one request in service at a time
// Notes: may hold off requests while its single answer is unsent
`timescale 1ns/100ps
`include "ctrt_cfg.svh"
module ctrt_responder #(
   parameter int TID_W = `CTRT_TID_W,
   parameter int ADDR_W = `CTRT_ADDR_W,
   parameter int DATA_W = `CTRT_DATA_W,
   parameter int MEM_DEPTH = `CTRT_MEM_DEPTH
) (
   input wire logic sys_clk,
   input wire logic nrst,
   ctrt_link_if.responder link,
   input wire logic fail_next,
   input wire logic conflict_next,
   output logic served_valid,
   output ctrt_pkg::ctrt_req_e served_kind
);
   localparam int MW = $clog2(MEM_DEPTH);

   typedef struct packed {
      logic req_ready;
      logic rsp_v;
      ctrt_pkg::ctrt_rsp_e rsp_code;
      logic [TID_W-1:0] rsp_tid;
      logic [DATA_W-1:0] rsp_data;
      logic served;
      ctrt_pkg::ctrt_req_e served_kind;
      logic [MEM_DEPTH-1:0][DATA_W-1:0] mem;
   } ctrt_rsp_state_s;

   ctrt_rsp_state_s q;
   ctrt_rsp_state_s d;

   // one request in, at most one answer out per cycle
   always_comb begin
      logic [MW-1:0] idx;
      d = q;
      idx = link.req_addr[MW-1:0];
      d.served = 1'b0;
      if (q.rsp_v && link.rsp_ready) begin
         d.rsp_v = 1'b0;
      end
      if (link.req_valid && q.req_ready) begin
         d.served = 1'b1;
         d.served_kind = link.req_kind;
         d.rsp_tid = link.req_tid;
         d.rsp_data = q.mem[idx];
         if (link.req_kind == ctrt_pkg::ctrt_rq_write_nr) begin
            // posted write: never answered, even on failure
            if (!fail_next) begin
               d.mem[idx] = link.req_data;
            end
         end else if (fail_next) begin
            d.rsp_v = 1'b1;
            d.rsp_code = ctrt_pkg::ctrt_rs_error;
         end else if (conflict_next) begin
            d.rsp_v = 1'b1;
            d.rsp_code = (link.req_kind == ctrt_pkg::ctrt_rq_read_owner) ?
                         ctrt_pkg::ctrt_rs_not_owner : ctrt_pkg::ctrt_rs_retry;
         end else begin
            d.rsp_v = 1'b1;
            case (link.req_kind)
               ctrt_pkg::ctrt_rq_read_owner: begin
                  // owner-to-element transfer uses the intervention code
                  d.rsp_code = ctrt_pkg::ctrt_rs_done_interv;
               end
               ctrt_pkg::ctrt_rq_castout: begin
                  d.mem[idx] = link.req_data;
                  d.rsp_code = ctrt_pkg::ctrt_rs_done;
               end
               default: begin
                  // home reads answer with memory data in a done
                  d.rsp_code = ctrt_pkg::ctrt_rs_done;
               end
            endcase
         end
      end
      d.req_ready = !d.rsp_v;
   end

   // state register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q <= `CTRT_RST_STATE;
      end else begin
         q <= d;
      end
   end

   assign link.req_ready = q.req_ready;
   assign link.rsp_valid = q.rsp_v;
   assign link.rsp_code = q.rsp_code;
   assign link.rsp_tid = q.rsp_tid;
   assign link.rsp_data = q.rsp_data;
   assign served_valid = q.served;
   assign served_kind = q.served_kind;
endmodule : ctrt_responder

/* ctrt_requester.sv */
// Purpose: requester end; tags requests with ids and matches answers
// Assumes: one responder on the link, user sides never stall results
// Notes: results and done pulses have no ready; the link input never stalls
`timescale 1ns/100ps
`include "ctrt_cfg.svh"
// Summary of operation
// - answers matched by id, any arrival order
// - no accepted request or matched answer is ever dropped; an unmatched answer only sets unmatched_err
// - response input accepted regardless of output backlog
// - castouts issued ahead of ordinary requests while an id is free; a posted write goes first when none is
// - peer work is requested and answered
// - home read answered with memory data
// - posted requests complete at once, no answer
// - done ends transaction, delivers read data
// - intervention codes only for element transfers
// - not-owner and retry reported as conflict
// - error answer reported as failed transaction
// - each answered request carries a unique id; posted requests carry id 0
// - id reused only after its answer
// - outstanding count bounded by parameter
module ctrt_requester #(
   parameter int MAX_OUT = `CTRT_MAX_OUT,
   parameter int TID_W = `CTRT_TID_W,
   parameter int ADDR_W = `CTRT_ADDR_W,
   parameter int DATA_W = `CTRT_DATA_W
) (
   input wire logic sys_clk,
   input wire logic nrst,
   ctrt_link_if.requester link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire ctrt_pkg::ctrt_req_e cmd_kind,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [DATA_W-1:0] cmd_data,
   input wire logic co_valid,
   output logic co_ready,
   input wire logic [ADDR_W-1:0] co_addr,
   input wire logic [DATA_W-1:0] co_data,
   output logic res_valid,
   output logic [TID_W-1:0] res_tid,
   output ctrt_pkg::ctrt_class_e res_class,
   output ctrt_pkg::ctrt_rsp_e res_code,
   output logic [DATA_W-1:0] res_data,
   output logic posted_done,
   output logic [MAX_OUT-1:0] busy_map,
   output logic unmatched_err,
   input wire logic unmatched_clr
);
   typedef struct packed {
      logic cmd_ready;
      logic co_ready;
      logic pc_v;
      ctrt_pkg::ctrt_req_e pc_kind;
      logic [ADDR_W-1:0] pc_addr;
      logic [DATA_W-1:0] pc_data;
      logic po_v;
      logic [ADDR_W-1:0] po_addr;
      logic [DATA_W-1:0] po_data;
      logic req_v;
      ctrt_pkg::ctrt_req_e req_kind;
      logic [TID_W-1:0] req_tid;
      logic [ADDR_W-1:0] req_addr;
      logic [DATA_W-1:0] req_data;
      logic [MAX_OUT-1:0] busy;
      logic [MAX_OUT-1:0] home;
      logic rsp_ready;
      logic res_v;
      logic [TID_W-1:0] res_tid;
      ctrt_pkg::ctrt_class_e res_class;
      ctrt_pkg::ctrt_rsp_e res_code;
      logic [DATA_W-1:0] res_data;
      logic posted_done;
      logic unmatched_err;
   } ctrt_req_state_s;

   ctrt_req_state_s q;
   ctrt_req_state_s d;

   // next state: answer intake, id pick, issue, then user intake
   always_comb begin
      logic have_free;
      logic [TID_W-1:0] free_tid;
      logic [TID_W-1:0] rt;
      d = q;
      have_free = 1'b0;
      free_tid = '0;
      rt = link.rsp_tid;
      d.res_v = 1'b0;
      d.posted_done = 1'b0;
      // clear first so a same-cycle unmatched answer still sets the flag
      if (unmatched_clr) begin
         d.unmatched_err = 1'b0;
      end
      if (q.req_v && link.req_ready) begin
         d.req_v = 1'b0;
      end
      // answers are always taken; lookup is by id alone
      if (link.rsp_valid && q.rsp_ready) begin
         if (int'(rt) < MAX_OUT && q.busy[rt]) begin
            d.busy[rt] = 1'b0;
            d.res_v = 1'b1;
            d.res_tid = rt;
            d.res_code = link.rsp_code;
            d.res_data = link.rsp_data;
            case (link.rsp_code)
               ctrt_pkg::ctrt_rs_done: begin
                  d.res_class = ctrt_pkg::ctrt_cl_complete;
               end
               ctrt_pkg::ctrt_rs_interv, ctrt_pkg::ctrt_rs_done_interv, ctrt_pkg::ctrt_rs_data_only: begin
                  // intervention from home memory is a protocol fault
                  d.res_class = q.home[rt] ? ctrt_pkg::ctrt_cl_error : ctrt_pkg::ctrt_cl_interv;
               end
               ctrt_pkg::ctrt_rs_not_owner, ctrt_pkg::ctrt_rs_retry: begin
                  d.res_class = ctrt_pkg::ctrt_cl_conflict;
               end
               default: begin
                  d.res_class = ctrt_pkg::ctrt_cl_error;
               end
            endcase
         end else begin
            d.unmatched_err = 1'b1;
         end
      end
      // lowest free id within the configured pool
      for (int i = MAX_OUT - 1; i >= 0; i--) begin
         if (!d.busy[i]) begin
            have_free = 1'b1;
            free_tid = TID_W'(i);
         end
      end
      // castout wins the output slot over a waiting command when an id is free; otherwise a posted command goes
      if (!d.req_v) begin
         if (q.po_v && have_free) begin
            d.po_v = 1'b0;
            d.req_v = 1'b1;
            d.req_kind = ctrt_pkg::ctrt_rq_castout;
            d.req_tid = free_tid;
            d.req_addr = q.po_addr;
            d.req_data = q.po_data;
            d.busy[free_tid] = 1'b1;
            d.home[free_tid] = 1'b1;
         end else if (q.pc_v && q.pc_kind == ctrt_pkg::ctrt_rq_write_nr) begin
            // posted kind: no id held, done as soon as it is sent
            d.pc_v = 1'b0;
            d.req_v = 1'b1;
            d.req_kind = q.pc_kind;
            d.req_tid = '0;
            d.req_addr = q.pc_addr;
            d.req_data = q.pc_data;
            d.posted_done = 1'b1;
         end else if (q.pc_v && have_free) begin
            d.pc_v = 1'b0;
            d.req_v = 1'b1;
            d.req_kind = q.pc_kind;
            d.req_tid = free_tid;
            d.req_addr = q.pc_addr;
            d.req_data = q.pc_data;
            d.busy[free_tid] = 1'b1;
            d.home[free_tid] = (q.pc_kind != ctrt_pkg::ctrt_rq_read_owner);
         end
      end
      // user intake into one holding slot per source; never overwritten
      if (cmd_valid && q.cmd_ready) begin
         d.pc_v = 1'b1;
         d.pc_kind = cmd_kind;
         d.pc_addr = cmd_addr;
         d.pc_data = cmd_data;
      end
      if (co_valid && q.co_ready) begin
         d.po_v = 1'b1;
         d.po_addr = co_addr;
         d.po_data = co_data;
      end
      d.cmd_ready = !d.pc_v;
      d.co_ready = !d.po_v;
      // answer intake has no dependency on the request output
      d.rsp_ready = 1'b1;
   end

   // state register; every output below is a field of q
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q <= `CTRT_RST_STATE;
      end else begin
         q <= d;
      end
   end

   assign link.req_valid = q.req_v;
   assign link.req_kind = q.req_kind;
   assign link.req_tid = q.req_tid;
   assign link.req_addr = q.req_addr;
   assign link.req_data = q.req_data;
   assign link.rsp_ready = q.rsp_ready;
   assign cmd_ready = q.cmd_ready;
   assign co_ready = q.co_ready;
   assign res_valid = q.res_v;
   assign res_tid = q.res_tid;
   assign res_class = q.res_class;
   assign res_code = q.res_code;
   assign res_data = q.res_data;
   assign posted_done = q.posted_done;
   assign busy_map = q.busy;
   assign unmatched_err = q.unmatched_err;
endmodule : ctrt_requester

/* ctrt_checker.sv */
// Purpose: link checks between requester and responder
// Assumes: answer one cycle after a take
// Notes: id map rebuilt from link beats only
`timescale 1ns/100ps
module ctrt_checker #(
   parameter int MAX_OUT = 4,
   parameter int TID_W = 2,
   parameter int ADDR_W = 8
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire ctrt_pkg::ctrt_req_e req_kind,
   input wire logic [TID_W-1:0] req_tid,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire ctrt_pkg::ctrt_rsp_e rsp_code,
   input wire logic [TID_W-1:0] rsp_tid
);
   logic [2**TID_W-1:0] busy_q, busy_d;
   logic tk, np;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   // take strobe; np marks kinds that expect an answer
   assign tk = req_valid && req_ready;
   assign np = req_kind != ctrt_pkg::ctrt_rq_write_nr;
   // ids in flight; set after clear since a freed id may go out again
   always_comb begin
      busy_d = busy_q;
      if (rsp_valid && rsp_ready) busy_d[rsp_tid] = 1'h0;
      if (tk && np) busy_d[req_tid] = 1'h1;
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) busy_q <= '0;
      else busy_q <= busy_d;
   end
   AST_REQ_HOLD: assert property (req_valid && !req_ready |=> req_valid && $stable(req_tid) && $stable(req_addr))
      else $error("waiting request dropped or changed");
   AST_RSP_READY: assert property ($past(nrst) |-> rsp_ready)
      else $error("answer input not ready");
   AST_ANSWER: assert property (tk && np |=> rsp_valid && rsp_tid == $past(req_tid))
      else $error("no answer with matching id");
   AST_POSTED: assert property (tk && !np |=> !rsp_valid)
      else $error("answer to a posted request");
   AST_ID_FREE: assert property (req_valid && np |-> !busy_q[req_tid])
      else $error("id reused while in flight");
   AST_ID_BOUND: assert property (req_valid && np |-> req_tid < MAX_OUT)
      else $error("id beyond outstanding limit");
   AST_READY_BACK: assert property (rsp_valid && rsp_ready |=> req_ready)
      else $error("request input stays closed");
   AST_HOME_CODE:
      assert property (tk && np && req_kind != ctrt_pkg::ctrt_rq_read_owner |=>
         !(rsp_code inside {[ctrt_pkg::ctrt_rs_interv:ctrt_pkg::ctrt_rs_data_only]}))
      else $error("element-only answer to home request");
endmodule : ctrt_checker

/* coherent_txn_request_response_tracker_tb_top.sv */
// Purpose: bench for requester and responder joined by the link
// Assumes: responder memory starts at zero
// Notes: a second requester meets a bench driver of stray answers
`timescale 1ns/100ps
module coherent_txn_request_response_tracker_tb_top;
   localparam ctrt_pkg::ctrt_req_e RH = ctrt_pkg::ctrt_rq_read_home, RO = ctrt_pkg::ctrt_rq_read_owner;
   localparam ctrt_pkg::ctrt_req_e RF = ctrt_pkg::ctrt_rq_rfo_home, WN = ctrt_pkg::ctrt_rq_write_nr;
   localparam ctrt_pkg::ctrt_req_e CO = ctrt_pkg::ctrt_rq_castout;
   localparam ctrt_pkg::ctrt_class_e KOK = ctrt_pkg::ctrt_cl_complete, KIV = ctrt_pkg::ctrt_cl_interv;
   localparam ctrt_pkg::ctrt_class_e KCF = ctrt_pkg::ctrt_cl_conflict, KER = ctrt_pkg::ctrt_cl_error;
   localparam ctrt_pkg::ctrt_rsp_e DN = ctrt_pkg::ctrt_rs_done, DI = ctrt_pkg::ctrt_rs_done_interv;
   localparam ctrt_pkg::ctrt_rsp_e NO = ctrt_pkg::ctrt_rs_not_owner, RT = ctrt_pkg::ctrt_rs_retry;
   localparam ctrt_pkg::ctrt_rsp_e ER = ctrt_pkg::ctrt_rs_error;
   logic sys_clk = 1'h0;
   logic nrst = 1'h0;
   logic cmd_valid = 1'h0, co_valid = 1'h0, unmatched_clr = 1'h0, fail_next = 1'h0, conflict_next = 1'h0;
   ctrt_pkg::ctrt_req_e cmd_kind = RH;
   logic [7:0] cmd_addr = 8'h00, co_addr = 8'h00;
   logic [31:0] cmd_data = 32'h0, co_data = 32'h0, res_data, res_xor = 32'h0;
   logic cmd_ready, co_ready, res_valid, posted_done, unmatched_err, served_valid, unmatched_err_b;
   logic [1:0] res_tid;
   logic [3:0] busy_map;
   ctrt_pkg::ctrt_class_e res_class;
   ctrt_pkg::ctrt_rsp_e res_code;
   ctrt_pkg::ctrt_req_e served_kind;
   int failures = 0, total_checks = 0, cycles = 0, res_count = 0;
   // 200 MHz
   always #2.5 sys_clk = ~sys_clk;
   ctrt_link_if link (.sys_clk(sys_clk), .nrst(nrst));
   ctrt_link_if link_b (.sys_clk(sys_clk), .nrst(nrst));
   ctrt_requester i_ctrt_requester (.sys_clk(sys_clk), .nrst(nrst), .link(link.requester), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .co_valid(co_valid),
      .co_ready(co_ready), .co_addr(co_addr), .co_data(co_data), .res_valid(res_valid), .res_tid(res_tid),
      .res_class(res_class), .res_code(res_code), .res_data(res_data), .posted_done(posted_done),
      .busy_map(busy_map), .unmatched_err(unmatched_err), .unmatched_clr(unmatched_clr));
   // stray-answer victim; never issues, so only its answer input matters
   ctrt_requester i_ctrt_requester_b (.sys_clk(sys_clk), .nrst(nrst), .link(link_b.requester), .cmd_valid(1'h0),
      .cmd_ready(), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .co_valid(1'h0),
      .co_ready(), .co_addr(co_addr), .co_data(co_data), .res_valid(), .res_tid(), .res_class(), .res_code(),
      .res_data(), .posted_done(), .busy_map(), .unmatched_err(unmatched_err_b), .unmatched_clr(unmatched_clr));
   ctrt_responder i_ctrt_responder (.sys_clk(sys_clk), .nrst(nrst), .link(link.responder), .fail_next(fail_next),
      .conflict_next(conflict_next), .served_valid(served_valid), .served_kind(served_kind));
   ctrt_checker #(.MAX_OUT(4)) i_ctrt_checker (.sys_clk(sys_clk), .nrst(nrst), .req_valid(link.req_valid),
      .req_ready(link.req_ready), .req_kind(link.req_kind), .req_tid(link.req_tid), .req_addr(link.req_addr),
      .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .rsp_code(link.rsp_code), .rsp_tid(link.rsp_tid));
   // answer tally; xor of data is order-free so any return order passes
   always @(posedge sys_clk) begin
      cycles++;
      if (res_valid === 1'h1) begin
         res_count++;
         res_xor ^= res_data;
      end
      if (cycles == 4000) begin
         failures++;
         final_report();
      end
   end
   task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word
   task automatic chk_cls(string what, ctrt_pkg::ctrt_class_e exp, ctrt_pkg::ctrt_class_e got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_cls
   task automatic final_report;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   // bounded wait for a level sampled high at a rising edge
   task automatic wait_hi(ref logic s);
      int n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (s !== 1'h1 && n < 50);
      // a wait that runs out is a failure, not a silent fall-through
      if (s !== 1'h1) begin
         failures++;
         $display("BAD wait expected 1 seen %b", s);
      end
   endtask : wait_hi
   // extra edge after release so cmd_valid never flips twice in one step
   task automatic send(ctrt_pkg::ctrt_req_e k, logic [7:0] a, logic [31:0] d);
      cmd_valid <= 1'h1;
      cmd_kind <= k;
      cmd_addr <= a;
      cmd_data <= d;
      wait_hi(cmd_ready);
      cmd_valid <= 1'h0;
      @(posedge sys_clk);
   endtask : send
   task automatic xfer(ctrt_pkg::ctrt_req_e k, logic [7:0] a, ctrt_pkg::ctrt_class_e c, ctrt_pkg::ctrt_rsp_e r,
      logic [31:0] d);
      send(k, a, 32'h0);
      wait_hi(res_valid);
      chk_cls("res_class", c, res_class);
      chk_word("res_code", 32'(r), 32'(res_code));
      if (c == KOK || c == KIV) chk_word("res_data", d, res_data);
   endtask : xfer
   task automatic t_post_read;
      send(WN, 8'h03, 32'hcafe0003);
      // done pulses one cycle after the take, for one cycle only
      @(posedge sys_clk);
      chk_word("posted_done", 32'h1, {31'h0, posted_done});
      @(posedge sys_clk);
      chk_word("posted_done low", 32'h0, {31'h0, posted_done});
      xfer(RH, 8'h03, KOK, DN, 32'hcafe0003);
      xfer(RO, 8'h03, KIV, DI, 32'hcafe0003);
   endtask : t_post_read
   // conflict on owner read, failure alone, both at once, conflict on a home kind
   task automatic t_conflict;
      for (int i = 1; i < 5; i++) begin
         conflict_next <= i[0] || i[2];
         fail_next <= i[1];
         xfer(i == 1 ? RO : RF, 8'h03, i[1] ? KER : KCF, i[1] ? ER : (i == 1 ? NO : RT), 32'h0);
      end
      conflict_next <= 1'h0;
      fail_next <= 1'h0;
   endtask : t_conflict
   // castout and read of one address offered together: read must see new word
   task automatic t_castout;
      logic [1:0] t0;
      co_valid <= 1'h1;
      co_addr <= 8'h05;
      co_data <= 32'h0000b0b0;
      cmd_valid <= 1'h1;
      cmd_kind <= RH;
      cmd_addr <= 8'h05;
      @(posedge sys_clk);
      co_valid <= 1'h0;
      cmd_valid <= 1'h0;
      wait_hi(served_valid);
      chk_word("served_kind", 32'(CO), 32'(served_kind));
      wait_hi(res_valid);
      chk_word("castout old word", 32'h0, res_data);
      t0 = res_tid;
      wait_hi(res_valid);
      chk_word("read after castout", 32'h0000b0b0, res_data);
      chk_word("distinct ids", 32'h1, {31'h0, res_tid != t0});
   endtask : t_castout
   task automatic t_burst;
      int base;
      logic [31:0] bx;
      // one edge first so the last answer of the previous scenario is already tallied
      @(posedge sys_clk);
      base = res_count;
      bx = res_xor;
      for (int i = 0; i < 6; i++) send(RH, 8'(i), 32'h0);
      for (int n = 0; n < 60 && res_count < base + 6; n++) @(posedge sys_clk);
      chk_word("answers", 32'(base + 6), 32'(res_count));
      chk_word("burst data", bx ^ 32'hcafe0003 ^ 32'h0000b0b0, res_xor);
      chk_word("busy_map", 32'h0, {28'h0, busy_map});
   endtask : t_burst
   // answer with an id never issued, on the second link
   task automatic t_stray;
      link_b.rsp_valid <= 1'h1;
      link_b.rsp_tid <= 2'h2;
      wait_hi(link_b.rsp_ready);
      link_b.rsp_valid <= 1'h0;
      repeat (2) @(posedge sys_clk);
      chk_word("stray flag", 32'h1, {31'h0, unmatched_err_b});
      chk_word("main flag", 32'h0, {31'h0, unmatched_err});
      unmatched_clr <= 1'h1;
      @(posedge sys_clk);
      unmatched_clr <= 1'h0;
      @(posedge sys_clk);
      chk_word("flag cleared", 32'h0, {31'h0, unmatched_err_b});
      // stray answer and clear in one cycle: the set must win
      link_b.rsp_valid <= 1'h1;
      unmatched_clr <= 1'h1;
      @(posedge sys_clk);
      link_b.rsp_valid <= 1'h0;
      unmatched_clr <= 1'h0;
      @(posedge sys_clk);
      chk_word("set over clear", 32'h1, {31'h0, unmatched_err_b});
   endtask : t_stray
   initial begin
      link_b.req_ready = 1'h0;
      link_b.rsp_valid = 1'h0;
      link_b.rsp_code = ctrt_pkg::ctrt_rs_done;
      link_b.rsp_tid = 2'h0;
      link_b.rsp_data = 32'h0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'h1;
      repeat (2) @(posedge sys_clk);
      t_post_read();
      t_conflict();
      t_castout();
      t_burst();
      t_stray();
      final_report();
   end
endmodule : coherent_txn_request_response_tracker_tb_top
